// ==== design/mdb_drive_regs.sv ====
/*
 drive end: motor drive register bank answering link requests.
 assumes one request at a time and drive inputs synchronous to sys_clk.
*/
// Implementation choice: the AHB-Lite slave port.
// Overview of operation
// - answer read-multiple and write-single requests
// - write-multiple only within registers one to four
// - master sends register number minus one
// - only one of Modbus or CAN active
// - option module disables Modbus and CAN
// - control and speed act only when source four
// - ramp applies while fieldbus ramp enabled
// - ramp value limited to 0..60000 hundredths
// - registers six to twenty-four always readable
// - control bit zero runs or stops
// - control bit one requests fast stop
// - control bit two clears active faults
// - master clears reset bit after fault clears
// - control bit three issues coast stop
// - speed setpoint in tenths of hertz
// - torque setpoint in tenths of percent
// - status running, tripped, inhibit bits
// - status maintenance and standby bits
// - status ready bit from four conditions
// - high byte holds fault number when tripped
`timescale 1ns/100ps
`include "mdb_map.svh"
module mdb_drive_regs
    import mdb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sys_ce,
    mdb_link_if.dev link,
    input wire logic [1:0] link_select,
    input wire logic option_module_present,
    input wire logic [3:0] command_source_select,
    input wire logic fieldbus_ramp_enable,
    input wire logic drive_running,
    input wire logic drive_tripped,
    input wire logic safe_halt_input_open,
    input wire logic maint_time_reached,
    input wire logic standby_active,
    input wire logic mains_present,
    input wire logic enable_input_present,
    input wire logic [7:0] fault_number,
    input wire logic [17:0][15:0] monitor_words,
    output logic modbus_enable_q,
    output logic can_enable_q,
    output logic run_enable_q,
    output logic fast_stop_q,
    output logic fault_reset_q,
    output logic coast_stop_q,
    output logic [15:0] speed_ref_q,
    output logic [15:0] torque_ref_q,
    output logic [15:0] ramp_time_q,
    output logic ramp_apply_q
);

////////////////////////////////////////////////////////////////////////////////

    mdb_dev_state_t state_q;
    mdb_word_t control_q;
    mdb_word_t speed_q;
    mdb_word_t torque_q;
    mdb_word_t ramp_q;
    mdb_word_t cur_q;
    logic [7:0] left_q;
    logic [7:0] exc_q;
    logic bulk_ok_q;
    logic rsp_valid_q;
    logic [7:0] rsp_exc_q;
    mdb_word_t rsp_data_q;
    logic rsp_last_q;

    function automatic logic writable(input mdb_word_t num);
        writable = num >= `MDB_REG_CONTROL && num <= `MDB_REG_RAMP;
    endfunction

    function automatic logic value_ok(input mdb_word_t num, input mdb_word_t val);
        value_ok = (num != `MDB_REG_RAMP) || (val <= `MDB_RAMP_MAX);
    endfunction

////////////////////////////////////////////////////////////////////////////////
// decoding

    wire modbus_on = (link_select == `MDB_SEL_MODBUS) && !option_module_present;
    wire can_on = (link_select == `MDB_SEL_CAN) && !option_module_present;
    wire cmd_ok = (command_source_select == `MDB_CMD_SRC_FIELDBUS) && !option_module_present;
    wire take = link.req_valid && modbus_on;
    wire is_idle = state_q == MDB_DEV_IDLE;
    wire is_collect = state_q == MDB_DEV_COLLECT;
    wire fn_read = link.req_func == `MDB_FN_READ_MULTI;
    wire fn_single = link.req_func == `MDB_FN_WRITE_SINGLE;
    wire fn_multi = link.req_func == `MDB_FN_WRITE_MULTI;
    // wire address is zero based, register numbers are one based
    wire [15:0] first_num = link.req_addr + `MDB_REG_ONE;
    wire [16:0] last_num = {1'b0, first_num} + {9'h000, link.req_qty} - 17'h00001;
    wire qty_ok = link.req_qty >= `MDB_QTY_ONE;
    wire read_range = qty_ok && ((first_num >= `MDB_REG_CONTROL && last_num <= {1'b0, `MDB_REG_RAMP}) ||
                      (first_num >= `MDB_REG_STATUS && last_num <= {1'b0, `MDB_REG_MON_LAST}));
    wire bulk_range = qty_ok && first_num >= `MDB_REG_CONTROL && last_num <= {1'b0, `MDB_REG_RAMP};
    wire [15:0] wr_num = is_collect ? cur_q : first_num;
    wire [15:0] wr_val = link.req_data;
    wire wr_allowed = (is_idle && fn_single) || (is_idle && fn_multi && bulk_range) ||
                      (is_collect && bulk_ok_q);
    wire wr_en = take && wr_allowed && writable(wr_num) && value_ok(wr_num, wr_val);
    wire val_bad = take && wr_allowed && writable(wr_num) && !value_ok(wr_num, wr_val);

    wire status_ready = mains_present && !safe_halt_input_open && !drive_tripped && enable_input_present;
    wire [7:0] status_low = {1'b0, status_ready, standby_active, maint_time_reached,
                             safe_halt_input_open, 1'b0, drive_tripped, drive_running};
    wire [7:0] status_high = drive_tripped ? fault_number : `MDB_BYTE_ZERO;
    wire [15:0] mon_index = cur_q - `MDB_REG_MON_FIRST;

    function automatic mdb_word_t read_word(input mdb_word_t num);
        unique case (1'b1)
            num == `MDB_REG_CONTROL: read_word = control_q;
            num == `MDB_REG_SPEED: read_word = speed_q;
            num == `MDB_REG_TORQUE: read_word = torque_q;
            num == `MDB_REG_RAMP: read_word = ramp_q;
            num == `MDB_REG_STATUS: read_word = {status_high, status_low};
            num >= `MDB_REG_MON_FIRST && num <= `MDB_REG_MON_LAST: read_word = monitor_words[mon_index[4:0]];
            default: read_word = `MDB_WORD_ZERO;
        endcase
    endfunction

////////////////////////////////////////////////////////////////////////////////
// holding registers

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            control_q <= `MDB_WORD_ZERO;
            speed_q <= `MDB_WORD_ZERO;
            torque_q <= `MDB_WORD_ZERO;
            ramp_q <= `MDB_WORD_ZERO;
        end
        else if (sys_ce && wr_en)
        begin
            unique case (1'b1)
                wr_num == `MDB_REG_CONTROL: control_q <= wr_val;
                wr_num == `MDB_REG_SPEED: speed_q <= wr_val;
                wr_num == `MDB_REG_TORQUE: torque_q <= wr_val;
                default: ramp_q <= wr_val;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// drive outputs; control and speed fall to stop unless the bus commands

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            modbus_enable_q <= 1'b0;
            can_enable_q <= 1'b0;
            run_enable_q <= 1'b0;
            fast_stop_q <= 1'b0;
            fault_reset_q <= 1'b0;
            coast_stop_q <= 1'b0;
            speed_ref_q <= `MDB_WORD_ZERO;
            torque_ref_q <= `MDB_WORD_ZERO;
            ramp_time_q <= `MDB_WORD_ZERO;
            ramp_apply_q <= 1'b0;
        end
        else if (sys_ce)
        begin
            modbus_enable_q <= modbus_on;
            can_enable_q <= can_on;
            run_enable_q <= cmd_ok && control_q[`MDB_CW_RUN];
            fast_stop_q <= cmd_ok && control_q[`MDB_CW_FAST_STOP];
            // stays up until the master drops bit two
            fault_reset_q <= cmd_ok && control_q[`MDB_CW_FAULT_RESET];
            coast_stop_q <= cmd_ok && control_q[`MDB_CW_COAST];
            speed_ref_q <= cmd_ok ? speed_q : `MDB_WORD_ZERO;
            torque_ref_q <= torque_q;
            ramp_time_q <= ramp_q;
            ramp_apply_q <= fieldbus_ramp_enable;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// request sequencer; answers are one-cycle beats

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q <= MDB_DEV_IDLE;
            cur_q <= `MDB_WORD_ZERO;
            left_q <= `MDB_BYTE_ZERO;
            exc_q <= `MDB_EXC_NONE;
            bulk_ok_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_exc_q <= `MDB_EXC_NONE;
            rsp_data_q <= `MDB_WORD_ZERO;
            rsp_last_q <= 1'b0;
        end
        else if (sys_ce)
        begin
            rsp_valid_q <= 1'b0;
            rsp_last_q <= 1'b0;
            unique case (state_q)
                MDB_DEV_OFF:
                begin
                    // traffic is dropped while the port is disabled
                    if (modbus_on)
                        state_q <= MDB_DEV_IDLE;
                end
                MDB_DEV_IDLE:
                begin
                    if (!modbus_on)
                        state_q <= MDB_DEV_OFF;
                    else if (take && fn_read && read_range)
                    begin
                        cur_q <= first_num;
                        left_q <= link.req_qty;
                        state_q <= MDB_DEV_READ;
                    end
                    else if (take && fn_multi && !link.req_last)
                    begin
                        cur_q <= first_num + `MDB_REG_ONE;
                        bulk_ok_q <= bulk_range;
                        exc_q <= !bulk_range ? `MDB_EXC_ADDRESS : (val_bad ? `MDB_EXC_VALUE : `MDB_EXC_NONE);
                        state_q <= MDB_DEV_COLLECT;
                    end
                    else if (take)
                    begin
                        rsp_valid_q <= 1'b1;
                        rsp_last_q <= 1'b1;
                        rsp_data_q <= link.req_data;
                        if (!(fn_read || fn_single || fn_multi))
                            rsp_exc_q <= `MDB_EXC_FUNCTION;
                        else if (fn_read && !qty_ok)
                            rsp_exc_q <= `MDB_EXC_VALUE;
                        else if (fn_read || (fn_single && !writable(first_num)) || (fn_multi && !bulk_range))
                            rsp_exc_q <= `MDB_EXC_ADDRESS;
                        else
                            rsp_exc_q <= val_bad ? `MDB_EXC_VALUE : `MDB_EXC_NONE;
                    end
                end
                MDB_DEV_READ:
                begin
                    rsp_valid_q <= 1'b1;
                    rsp_exc_q <= `MDB_EXC_NONE;
                    rsp_data_q <= read_word(cur_q);
                    rsp_last_q <= left_q == `MDB_QTY_ONE;
                    cur_q <= cur_q + `MDB_REG_ONE;
                    left_q <= left_q - `MDB_QTY_ONE;
                    if (left_q == `MDB_QTY_ONE)
                        state_q <= MDB_DEV_IDLE;
                end
                MDB_DEV_COLLECT:
                begin
                    if (take)
                    begin
                        cur_q <= cur_q + `MDB_REG_ONE;
                        if (val_bad && exc_q == `MDB_EXC_NONE)
                            exc_q <= `MDB_EXC_VALUE;
                        if (link.req_last)
                        begin
                            rsp_valid_q <= 1'b1;
                            rsp_last_q <= 1'b1;
                            rsp_data_q <= link.req_data;
                            rsp_exc_q <= (val_bad && exc_q == `MDB_EXC_NONE) ? `MDB_EXC_VALUE : exc_q;
                            state_q <= MDB_DEV_IDLE;
                        end
                    end
                end
                default:
                    state_q <= MDB_DEV_IDLE;
            endcase
        end
    end

    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_exc = rsp_exc_q;
    assign link.rsp_data = rsp_data_q;
    assign link.rsp_last = rsp_last_q;

endmodule

// ==== design/mdb_map.svh ====
/*
 register numbers, codes, bit positions and limits of the link, and the controller's software map.
 assumes plain textual inclusion.
*/
`ifndef MDB_MAP_SVH
`define MDB_MAP_SVH

// drive register numbers as counted on the wire plus one
`define MDB_REG_CONTROL 16'h0001
`define MDB_REG_SPEED 16'h0002
`define MDB_REG_TORQUE 16'h0003
`define MDB_REG_RAMP 16'h0004
`define MDB_REG_STATUS 16'h0006
`define MDB_REG_MON_FIRST 16'h0007
`define MDB_REG_MON_LAST 16'h0018
`define MDB_REG_ONE 16'h0001

// function and exception codes
`define MDB_FN_READ_MULTI 8'h03
`define MDB_FN_WRITE_SINGLE 8'h06
`define MDB_FN_WRITE_MULTI 8'h10
`define MDB_EXC_NONE 8'h00
`define MDB_EXC_FUNCTION 8'h01
`define MDB_EXC_ADDRESS 8'h02
`define MDB_EXC_VALUE 8'h03

// control word bits
`define MDB_CW_RUN 0
`define MDB_CW_FAST_STOP 1
`define MDB_CW_FAULT_RESET 2
`define MDB_CW_COAST 3

// status byte bits
`define MDB_ST_RUNNING 0
`define MDB_ST_TRIPPED 1
`define MDB_ST_INHIBIT 3
`define MDB_ST_MAINT 4
`define MDB_ST_STANDBY 5
`define MDB_ST_READY 6

// configuration values and limits
`define MDB_RAMP_MAX 16'hEA60
`define MDB_CMD_SRC_FIELDBUS 4'h4
`define MDB_SEL_NONE 2'h0
`define MDB_SEL_MODBUS 2'h1
`define MDB_SEL_CAN 2'h2
`define MDB_WORD_ZERO 16'h0000
`define MDB_BYTE_ZERO 8'h00
`define MDB_QTY_ONE 8'h01

// link controller software map, byte offsets
`define MDB_AHB_CMD 8'h00
`define MDB_AHB_STATUS 8'h04
`define MDB_AHB_DATA_BASE 8'h80
`define MDB_CMD_GO 31
`define MDB_STAT_BUSY 0
`define MDB_STAT_DONE 1
`define MDB_STAT_EXC 2
`define MDB_BUF_WORDS 32

`endif

// ==== design/mdb_pkg.sv ====
/*
 types shared by both ends of the link.
 assumes nothing of its importers.
*/
package mdb_pkg;

    typedef enum logic [3:0]
    {
        MDB_DEV_IDLE = 4'b0001,
        MDB_DEV_READ = 4'b0010,
        MDB_DEV_COLLECT = 4'b0100,
        MDB_DEV_OFF = 4'b1000
    } mdb_dev_state_t;

    typedef enum logic [2:0]
    {
        MDB_MST_IDLE = 3'b001,
        MDB_MST_SEND = 3'b010,
        MDB_MST_WAIT = 3'b100
    } mdb_mst_state_t;

    typedef logic [15:0] mdb_word_t;

endpackage

// ==== design/mdb_link_if.sv ====
/*
 frame link between the master end and the drive end.
 assumes one shared sys_clk; beats are never stalled.
*/
`timescale 1ns/100ps
interface mdb_link_if;
    logic req_valid;
    logic [7:0] req_func;
    logic [15:0] req_addr;
    logic [7:0] req_qty;
    logic [15:0] req_data;
    logic req_last;
    logic rsp_valid;
    logic [7:0] rsp_exc;
    logic [15:0] rsp_data;
    logic rsp_last;

    modport dev
    (
        input req_valid, req_func, req_addr, req_qty, req_data, req_last,
        output rsp_valid, rsp_exc, rsp_data, rsp_last
    );

    modport mst
    (
        output req_valid, req_func, req_addr, req_qty, req_data, req_last,
        input rsp_valid, rsp_exc, rsp_data, rsp_last
    );
endinterface

// ==== design/mdb_link_master.sv ====
/*
 master end: AHB-Lite slave with command, status and a 32-word buffer, driving the link.
 assumes one AHB master, word transfers only.
*/
`timescale 1ns/100ps
`include "mdb_map.svh"
module mdb_link_master
    import mdb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sys_ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata_q,
    output logic hreadyout_q,
    output logic hresp_q,
    mdb_link_if.mst link
);

////////////////////////////////////////////////////////////////////////////////

    mdb_mst_state_t state_q;
    mdb_word_t buf_q [`MDB_BUF_WORDS];
    logic [7:0] fn_q;
    mdb_word_t num_q;
    logic [7:0] qty_q;
    logic [4:0] idx_q;
    logic done_q;
    logic [7:0] exc_q;
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic req_valid_q;
    logic [7:0] req_func_q;
    mdb_word_t req_addr_q;
    logic [7:0] req_qty_q;
    mdb_word_t req_data_q;
    logic req_last_q;

    // ramp values beyond the drive's range are clamped rather than sent
    function automatic mdb_word_t limit(input mdb_word_t num, input mdb_word_t val);
        limit = (num == `MDB_REG_RAMP && val > `MDB_RAMP_MAX) ? `MDB_RAMP_MAX : val;
    endfunction

////////////////////////////////////////////////////////////////////////////////
// bus decode

    wire ap_take = hsel && htrans[1] && hready;
    wire dp_wr = ap_wr_q && sys_ce;
    wire is_buf = ap_addr_q >= `MDB_AHB_DATA_BASE;
    wire rd_buf = haddr[7:0] >= `MDB_AHB_DATA_BASE;
    wire busy = state_q != MDB_MST_IDLE;
    wire go = dp_wr && ap_addr_q == `MDB_AHB_CMD && hwdata[`MDB_CMD_GO] && !busy;
    wire [15:0] go_num = {1'b0, hwdata[30:16]};
    wire [7:0] go_qty = hwdata[15:8];
    wire go_multi = hwdata[7:0] == `MDB_FN_WRITE_MULTI;
    wire go_last = !go_multi || go_qty <= `MDB_QTY_ONE;
    wire [4:0] next_idx = idx_q + 5'h01;
    wire send_last = {3'h0, next_idx} >= qty_q;
    wire rsp_store = state_q == MDB_MST_WAIT && link.rsp_valid && fn_q == `MDB_FN_READ_MULTI &&
                     link.rsp_exc == `MDB_EXC_NONE;
    wire rsp_end = state_q == MDB_MST_WAIT && link.rsp_valid && link.rsp_last;
    wire done_clr = dp_wr && ap_addr_q == `MDB_AHB_STATUS && hwdata[`MDB_STAT_DONE];
    wire [31:0] status_word = {16'h0000, exc_q, 5'h00, exc_q != `MDB_EXC_NONE, done_q, busy};
    wire [31:0] cmd_word = {num_q, qty_q, fn_q};
    wire [31:0] rd_mux = rd_buf ? {16'h0000, buf_q[haddr[6:2]]} :
                         haddr[7:0] == `MDB_AHB_STATUS ? status_word :
                         haddr[7:0] == `MDB_AHB_CMD ? cmd_word : 32'h00000000;

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave: zero wait states, read data registered at the address phase

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else if (sys_ce)
        begin
            ap_wr_q <= ap_take && hwrite;
            ap_addr_q <= haddr[7:0];
            if (ap_take && !hwrite)
                hrdata_q <= rd_mux;
        end
    end

    // the link owns the buffer while busy; software writes are dropped
    always_ff @(posedge sys_clk)
    begin
        if (sys_ce && rsp_store)
            buf_q[idx_q] <= link.rsp_data;
        else if (dp_wr && is_buf && !busy)
            buf_q[ap_addr_q[6:2]] <= hwdata[15:0];
    end

////////////////////////////////////////////////////////////////////////////////
// request sequencer

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q <= MDB_MST_IDLE;
            fn_q <= `MDB_BYTE_ZERO;
            num_q <= `MDB_WORD_ZERO;
            qty_q <= `MDB_BYTE_ZERO;
            idx_q <= 5'h00;
            done_q <= 1'b0;
            exc_q <= `MDB_EXC_NONE;
            req_valid_q <= 1'b0;
            req_func_q <= `MDB_BYTE_ZERO;
            req_addr_q <= `MDB_WORD_ZERO;
            req_qty_q <= `MDB_BYTE_ZERO;
            req_data_q <= `MDB_WORD_ZERO;
            req_last_q <= 1'b0;
        end
        else if (sys_ce)
        begin
            req_valid_q <= 1'b0;
            req_last_q <= 1'b0;
            // a new answer wins over a clear in the same cycle
            if (rsp_end)
                done_q <= 1'b1;
            else if (done_clr)
                done_q <= 1'b0;
            unique case (state_q)
                MDB_MST_IDLE:
                begin
                    if (go)
                    begin
                        fn_q <= hwdata[7:0];
                        num_q <= go_num;
                        qty_q <= go_qty;
                        idx_q <= go_last ? 5'h00 : 5'h01;
                        req_valid_q <= 1'b1;
                        req_func_q <= hwdata[7:0];
                        req_addr_q <= go_num - `MDB_REG_ONE;
                        req_qty_q <= go_qty;
                        req_data_q <= limit(go_num, buf_q[0]);
                        req_last_q <= go_last;
                        state_q <= go_last ? MDB_MST_WAIT : MDB_MST_SEND;
                    end
                end
                MDB_MST_SEND:
                begin
                    req_valid_q <= 1'b1;
                    req_data_q <= limit(num_q + {11'h000, idx_q}, buf_q[idx_q]);
                    req_last_q <= send_last;
                    idx_q <= send_last ? 5'h00 : next_idx;
                    if (send_last)
                        state_q <= MDB_MST_WAIT;
                end
                MDB_MST_WAIT:
                begin
                    if (rsp_store)
                        idx_q <= idx_q + 5'h01;
                    if (rsp_end)
                    begin
                        exc_q <= link.rsp_exc;
                        state_q <= MDB_MST_IDLE;
                    end
                end
                default:
                    state_q <= MDB_MST_IDLE;
            endcase
        end
    end

    assign link.req_valid = req_valid_q;
    assign link.req_func = req_func_q;
    assign link.req_addr = req_addr_q;
    assign link.req_qty = req_qty_q;
    assign link.req_data = req_data_q;
    assign link.req_last = req_last_q;

endmodule

// ==== verif/mdb_link_checker.sv ====
/* link checker: timing and codes of answers on the frame link.
 assumes one clock and the Modbus port enabled. */
`timescale 1ns/100ps
module mdb_link_checker
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_qty,
    input wire logic [15:0] req_data,
    input wire logic req_last,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_exc,
    input wire logic [15:0] rsp_data,
    input wire logic rsp_last
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire rd = req_valid && req_func == 8'h03;
    wire wm = req_valid && req_last && req_func == 8'h10;
    wire [16:0] top = {1'b0, req_addr} + {9'h0, req_qty};
    // a read needs two cycles before its first word
    sequence s_rd_ok;
        rd && req_qty != 8'h00 && req_addr >= 16'h0005 && top <= 17'h00018 ##2 rsp_valid;
    endsequence
    sequence s_rd_two;
        rd && req_qty == 8'h02 ##2 rsp_valid;
    endsequence
    a_read_good: assert property (s_rd_ok |-> rsp_exc == 8'h00) else $error("read refused");
    a_read_burst: assert property (s_rd_two |-> !rsp_last ##1 rsp_valid && rsp_last) else $error("burst");
    a_status_zero: assert property ((rd && req_addr == 16'h0005) ##2 rsp_valid |-> rsp_data[7] == 1'b0 &&
        rsp_data[2] == 1'b0) else $error("spare bits");
    a_multi_range: assert property ((wm && top > 17'h00004) ##1 rsp_valid |-> rsp_exc == 8'h02)
        else $error("multi range");
    a_multi_good: assert property ((wm && top <= 17'h00004 && req_qty != 8'h00 && req_data <= 16'hEA60) ##1
        rsp_valid |-> rsp_exc == 8'h00 && rsp_last) else $error("multi refused");
    a_func_unknown: assert property ((req_valid && !(req_func inside {8'h03, 8'h06, 8'h10})) ##1 rsp_valid
        |-> rsp_exc == 8'h01) else $error("function");
    a_single_beat: assert property ((req_valid && req_func == 8'h06) ##1 rsp_valid |-> rsp_last)
        else $error("single");
    a_answer_gap: assert property (rsp_last |=> !rsp_valid) else $error("answer length");
endmodule

// ==== verif/tb_top.sv ====
/* bench: AHB-Lite tasks drive the master end, which talks to the drive end.
 assumes hready is the master end's own hreadyout. */
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, opt = 1'b0, ramp_en = 1'b1, run_in = 1'b0, trip = 1'b0, halt = 1'b0;
    logic maint = 1'b0, stby = 1'b0, mains = 1'b1, en_in = 1'b1, hreadyout_q, hresp_q;
    logic [1:0] htrans = 2'h0, link_sel = 2'h1;
    logic [3:0] src = 4'h4;
    logic [7:0] fault = 8'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_q, st, r;
    logic [17:0][15:0] mon = {18{16'h1234}};
    logic mb_en, can_en, run_en, fast, frst, coast, rapply;
    logic [15:0] spd, trq, rmp;
    wire [31:0] ctl = {27'h0, run_en, fast, frst, coast, rapply};
    logic [15:0] wv [4] = '{16'h0009, 16'h01F4, 16'h07D0, 16'hEA60};
    int miscompares = 0, checked = 0, cyc = 0;
    always #12.5 sys_clk = ~sys_clk;
    mdb_link_if link ();
    mdb_drive_regs i_mdb_drive_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(1'b1), .link(link),
        .link_select(link_sel), .option_module_present(opt), .command_source_select(src),
        .fieldbus_ramp_enable(ramp_en), .drive_running(run_in), .drive_tripped(trip), .safe_halt_input_open(halt),
        .maint_time_reached(maint), .standby_active(stby), .mains_present(mains), .enable_input_present(en_in),
        .fault_number(fault), .monitor_words(mon), .modbus_enable_q(mb_en), .can_enable_q(can_en),
        .run_enable_q(run_en), .fast_stop_q(fast), .fault_reset_q(frst), .coast_stop_q(coast), .speed_ref_q(spd),
        .torque_ref_q(trq), .ramp_time_q(rmp), .ramp_apply_q(rapply));
    mdb_link_master i_mdb_link_master (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_q),
        .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .link(link));
    mdb_link_checker i_mdb_link_checker (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(link.req_valid),
        .req_func(link.req_func), .req_addr(link.req_addr), .req_qty(link.req_qty), .req_data(link.req_data),
        .req_last(link.req_last), .rsp_valid(link.rsp_valid), .rsp_exc(link.rsp_exc), .rsp_data(link.rsp_data),
        .rsp_last(link.rsp_last));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout_q !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout_q !== 1'b1) @(posedge sys_clk);
        q = hrdata_q;
    endtask
    // clear done first: a stale answer must not count
    task cmd(input logic [15:0] n, input logic [7:0] q, input logic [7:0] f);
        ahb(1'b1, 8'h04, 32'h2, st);
        ahb(1'b1, 8'h00, {1'b1, n[14:0], q, f}, st);
        do ahb(1'b0, 8'h04, 32'h0, st); while (st[1] !== 1'b1);
    endtask
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (link.req_valid === 1'b1 && link.req_func === 8'h03) chk({16'h0, link.req_addr}, 32'h5);
        if (cyc == 5000)
        begin
            miscompares++;
            final_report;
        end
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) ahb(1'b1, 8'h80 + 8'(4 * i), {16'h0, wv[i]}, r);
        cmd(16'h1, 8'h4, 8'h10);
        chk({hresp_q, st[30:0]}, 32'h2);
        chk(ctl, 32'h13);
        chk({spd, trq}, 32'h01F407D0);
        chk({16'h0, rmp}, 32'hEA60);
        cmd(16'h2, 8'h4, 8'h10);
        chk(st, 32'h0206);
        cmd(16'h1, 8'h1, 8'h07);
        chk(st, 32'h0106);
        $display("test multi write done");
        ahb(1'b1, 8'h80, 32'h6, r);
        cmd(16'h1, 8'h1, 8'h06);
        chk(ctl, 32'h0D);
        ahb(1'b1, 8'h80, 32'h9, r);
        cmd(16'h1, 8'h1, 8'h06);
        chk(ctl, 32'h13);
        src <= 4'h0;
        {run_in, trip, halt, maint, stby, fault} <= {5'h1F, 8'h2A};
        $display("test control word done");
        cmd(16'h6, 8'h2, 8'h03);
        chk(ctl, 32'h01);
        ahb(1'b0, 8'h80, 32'h0, r);
        chk(r, 32'h2A3B);
        ahb(1'b0, 8'h84, 32'h0, r);
        chk(r, 32'h1234);
        {trip, halt} <= 2'h0;
        cmd(16'h6, 8'h1, 8'h03);
        ahb(1'b0, 8'h80, 32'h0, r);
        chk(r, 32'h0071);
        $display("test status done");
        link_sel <= 2'h2;
        repeat (3) @(posedge sys_clk);
        chk({30'h0, mb_en, can_en}, 32'h1);
        opt <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({30'h0, mb_en, can_en}, 32'h0);
        $display("test interface select done");
        final_report;
    end
endmodule
